// >>> mbpp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbpp_regs.svh"
module mbpp_top
  import mbpp_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        res_valid_in,
  input  wire logic [21:0] res_data_in,
  output logic             out_valid_out,
  output logic      [7:0]  out_byte_out,
  output logic      [21:0] out_norm_out
);

  // ========================================================================
  // Register state
  logic [10:0] ctrl_r,   ctrl_nxt;
  logic [21:0] peak_r,   peak_nxt;
  logic [21:0] thresh_r, thresh_nxt;
  logic [15:0] exceed_r, exceed_nxt;
  logic [5:0]  lutadr_r, lutadr_nxt;
  logic [31:0] rdata_r,  rdata_nxt;

  logic        table_access;
  mbpp_rect_e  rect_mode;
  mbpp_stat_e  stat_mode;
  logic        dyn_norm;
  logic [4:0]  static_shift;

  assign table_access = ctrl_r[`MBPP_CTRL_ACCESS];
  assign rect_mode    = mbpp_rect_e'(ctrl_r[`MBPP_CTRL_RECT_HI:
                                            `MBPP_CTRL_RECT_LO]);
  assign stat_mode    = mbpp_stat_e'(ctrl_r[`MBPP_CTRL_STAT_HI:
                                            `MBPP_CTRL_STAT_LO]);
  assign dyn_norm     = ctrl_r[`MBPP_CTRL_DYN];
  assign static_shift = ctrl_r[`MBPP_CTRL_SHF_HI:`MBPP_CTRL_SHF_LO];

  // ========================================================================
  // APB decode
  logic setup_ph;
  logic wr_acc;
  logic hit;
  logic sel_ctrl, sel_peak, sel_thr, sel_exc, sel_ladr, sel_ldat;

  assign setup_ph = psel_in & ~penable_in;
  assign wr_acc   = psel_in & penable_in & pwrite_in;
  assign sel_ctrl = (paddr_in == `MBPP_OFS_CTRL);
  assign sel_peak = (paddr_in == `MBPP_OFS_PEAK);
  assign sel_thr  = (paddr_in == `MBPP_OFS_THRESH);
  assign sel_exc  = (paddr_in == `MBPP_OFS_EXCEED);
  assign sel_ladr = (paddr_in == `MBPP_OFS_LUTADR);
  assign sel_ldat = (paddr_in == `MBPP_OFS_LUTDAT);
  assign hit      = sel_ctrl | sel_peak | sel_thr | sel_exc |
                    sel_ladr | sel_ldat;

  // No wait states: read data is captured in the setup cycle
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit;
  assign prdata_out  = rdata_r;

  // ========================================================================
  // Table memory
  mbpp_lut_if lut ();

  mbpp_lut_mem u_lut (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .port    (lut.mem)
  );

  // ========================================================================
  // Rectifier and table address
  logic signed [21:0] res_s;
  logic        [21:0] rect_val;
  logic        [7:0]  dp_addr;

  assign res_s = $signed(res_data_in);

  always_comb begin
    rect_val = res_data_in;
    unique case (rect_mode)
      MBPP_RECT_FULL: begin
        // Most negative value has no magnitude in range, so clamp it
        if (res_data_in == 22'h200000) begin
          rect_val = 22'h1fffff;
        end else if (res_data_in[21]) begin
          rect_val = 22'(-res_s);
        end
      end
      MBPP_RECT_HALF: begin
        if (res_data_in[21]) begin
          rect_val = 22'h000000;
        end
      end
      default: begin
        rect_val = res_data_in;
      end
    endcase
    // Out-of-range values saturate to the end entries of the table
    if (rect_val[21]) begin
      dp_addr = 8'h00;
    end else if (rect_val[20:8] != 13'h0000) begin
      dp_addr = 8'hff;
    end else begin
      dp_addr = rect_val[7:0];
    end
  end

  // Host owns the single table port while access is 0
  assign lut.addr  = table_access ? dp_addr[7:2] : lutadr_r;
  assign lut.we    = wr_acc & sel_ldat & ~table_access;
  assign lut.wdata = pwdata_in;

  // ========================================================================
  // Pipeline stage aligned with table read data
  logic        s1_valid_r, s1_valid_nxt;
  logic [21:0] s1_val_r,   s1_val_nxt;
  logic [1:0]  s1_bsel_r,  s1_bsel_nxt;

  always_comb begin
    s1_valid_nxt = res_valid_in;
    s1_val_nxt   = rect_val;
    s1_bsel_nxt  = dp_addr[1:0];
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_valid_r <= 1'b0;
      s1_val_r   <= 22'h000000;
      s1_bsel_r  <= 2'h0;
    end else begin
      s1_valid_r <= s1_valid_nxt;
      s1_val_r   <= s1_val_nxt;
      s1_bsel_r  <= s1_bsel_nxt;
    end
  end

  // ========================================================================
  // Table word, byte select and normaliser
  logic        [31:0] tword;
  logic        [4:0]  shift_amt;
  logic signed [21:0] shifted;
  logic        [21:0] norm_val;
  logic        [7:0]  byte_sel;
  logic               ov_nxt;
  logic        [7:0]  ob_nxt;
  logic        [21:0] on_nxt;
  logic               ov_r;
  logic        [7:0]  ob_r;
  logic        [21:0] on_r;

  always_comb begin
    tword = table_access ? lut.rdata : 32'h00000000;
    shift_amt = (dyn_norm && table_access) ? tword[26:22]
                                           : static_shift;
    if (shift_amt > `MBPP_SHIFT_MAX) begin
      shifted = 22'sh000000;
    end else begin
      shifted = $signed(s1_val_r) >>> shift_amt;
    end
    norm_val = dyn_norm ? 22'(shifted + $signed(tword[21:0]))
                        : shifted;
    byte_sel = tword[8*s1_bsel_r +: 8];
    ov_nxt   = s1_valid_r;
    ob_nxt   = s1_valid_r ? byte_sel : ob_r;
    on_nxt   = s1_valid_r ? norm_val : on_r;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ov_r <= 1'b0;
      ob_r <= 8'h00;
      on_r <= 22'h000000;
    end else begin
      ov_r <= ov_nxt;
      ob_r <= ob_nxt;
      on_r <= on_nxt;
    end
  end

  assign out_valid_out = ov_r;
  assign out_byte_out  = ob_r;
  assign out_norm_out  = on_r;

  // ========================================================================
  // Registers and statistics monitor
  logic [21:0] peak_base;
  logic [15:0] exc_base;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    thresh_nxt = thresh_r;
    lutadr_nxt = lutadr_r;
    if (wr_acc && sel_ctrl) begin
      ctrl_nxt = pwdata_in[10:0];
    end
    if (wr_acc && sel_thr) begin
      thresh_nxt = pwdata_in[21:0];
    end
    if (wr_acc && sel_ladr) begin
      lutadr_nxt = pwdata_in[5:0];
    end
    // A same-cycle result is compared against the freshly loaded value
    peak_base = (wr_acc && sel_peak) ? pwdata_in[21:0] : peak_r;
    exc_base  = (wr_acc && sel_exc) ? pwdata_in[15:0] : exceed_r;
    peak_nxt  = peak_base;
    exceed_nxt = exc_base;
    if (res_valid_in) begin
      unique case (stat_mode)
        MBPP_STAT_MAX: begin
          if (res_s > $signed(peak_base)) begin
            peak_nxt = res_data_in;
          end
        end
        MBPP_STAT_MIN: begin
          if (res_s < $signed(peak_base)) begin
            peak_nxt = res_data_in;
          end
        end
        MBPP_STAT_OVER: begin
          if (res_s > $signed(thresh_r) &&
              exc_base != 16'hffff) begin
            exceed_nxt = 16'(exc_base + 16'h0001);
          end
        end
        default: begin
          peak_nxt = peak_base;
        end
      endcase
    end
    rdata_nxt = rdata_r;
    if (setup_ph) begin
      rdata_nxt = 32'h00000000;
      if (sel_ctrl) rdata_nxt = {21'h000000, ctrl_r};
      if (sel_peak) rdata_nxt = {{10{peak_r[21]}}, peak_r};
      if (sel_thr)  rdata_nxt = {{10{thresh_r[21]}}, thresh_r};
      if (sel_exc)  rdata_nxt = {16'h0000, exceed_r};
      if (sel_ladr) rdata_nxt = {26'h0000000, lutadr_r};
      if (sel_ldat && !table_access) rdata_nxt = lut.rdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_r   <= `MBPP_RST_CTRL;
      peak_r   <= `MBPP_RST_PEAK;
      thresh_r <= `MBPP_RST_THRESH;
      exceed_r <= `MBPP_RST_EXCEED;
      lutadr_r <= 6'h00;
      rdata_r  <= 32'h00000000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      peak_r   <= peak_nxt;
      thresh_r <= thresh_nxt;
      exceed_r <= exceed_nxt;
      lutadr_r <= lutadr_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> mbpp_regs.svh
`ifndef MBPP_REGS_SVH
`define MBPP_REGS_SVH

// ==========================================================================
// Widths
`define MBPP_RES_W        22
`define MBPP_CNT_W        16
`define MBPP_ADDR_W       8
`define MBPP_LUT_AW       6
`define MBPP_SHIFT_W      5
`define MBPP_SHIFT_MAX    5'h0e

// ==========================================================================
// Register byte offsets
`define MBPP_OFS_CTRL     8'h00
`define MBPP_OFS_PEAK     8'h04
`define MBPP_OFS_THRESH   8'h08
`define MBPP_OFS_EXCEED   8'h0c
`define MBPP_OFS_LUTADR   8'h10
`define MBPP_OFS_LUTDAT   8'h14

// ==========================================================================
// Control register fields
`define MBPP_CTRL_ACCESS  0
`define MBPP_CTRL_RECT_LO 1
`define MBPP_CTRL_RECT_HI 2
`define MBPP_CTRL_STAT_LO 3
`define MBPP_CTRL_STAT_HI 4
`define MBPP_CTRL_DYN     5
`define MBPP_CTRL_SHF_LO  6
`define MBPP_CTRL_SHF_HI  10

// ==========================================================================
// Reset values
`define MBPP_RST_CTRL     11'h000
`define MBPP_RST_PEAK     22'h200000
`define MBPP_RST_THRESH   22'h000000
`define MBPP_RST_EXCEED   16'h0000

`endif

// >>> mbpp_pkg.sv
`default_nettype none
package mbpp_pkg;
  typedef enum logic [1:0] {
    MBPP_RECT_NONE = 2'h0,
    MBPP_RECT_FULL = 2'h1,
    MBPP_RECT_HALF = 2'h2,
    MBPP_RECT_RSVD = 2'h3
  } mbpp_rect_e;

  typedef enum logic [1:0] {
    MBPP_STAT_OFF  = 2'h0,
    MBPP_STAT_MAX  = 2'h1,
    MBPP_STAT_MIN  = 2'h2,
    MBPP_STAT_OVER = 2'h3
  } mbpp_stat_e;
endpackage
`default_nettype wire

// >>> mbpp_lut_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mbpp_lut_if;
  logic [5:0]  addr;
  logic        we;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport mem  (input addr, input we, input wdata, output rdata);
  modport user (output addr, output we, output wdata, input rdata);
endinterface
`default_nettype wire

// >>> mbpp_lut_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mbpp_lut_mem (
  input wire logic clk_in,
  input wire logic srst_in,
  mbpp_lut_if.mem  port
);
  logic [31:0] mem [0:63];
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // ========================================================================
  // Storage; write-then-read of one address sees old data for one cycle
  always_comb begin
    rdata_nxt = mem[port.addr];
  end

  always_ff @(posedge clk_in) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    if (srst_in) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign port.rdata = rdata_r;
endmodule
`default_nettype wire

// >>> mbpp_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mbpp_top_asserts (
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic [7:0]  paddr_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        res_valid_in,
  input wire logic [21:0] res_data_in,
  input wire logic        out_valid_out,
  input wire logic [7:0]  out_byte_out,
  input wire logic [21:0] out_norm_out
);
  // ========
  // Shadow of the access bit
  // Rebuilt from bus writes, since the register itself is out of sight
  logic acc_r;
  logic acc_nxt;
  logic acc_ph;
  logic mapped;
  assign acc_ph = psel_in && penable_in;
  // Unaligned offsets inside the map are unmapped too
  assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= 8'h14);
  always_comb begin
    acc_nxt = acc_r;
    if (acc_ph && pwrite_in && paddr_in == 8'h00) begin
      acc_nxt = pwdata_in[0];
    end
  end
  always_ff @(posedge clk_in) begin
    acc_r <= srst_in ? 1'h0 : acc_nxt;
  end
  // ========
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_take;
    res_valid_in;
  endsequence
  sequence s_emit;
    ##2 out_valid_out;
  endsequence
  valid_lat_a: assert property (s_take |-> s_emit)
    else $error("result latency wrong");
  no_spur_a: assert property (!res_valid_in |-> ##2 !out_valid_out)
    else $error("spurious output strobe");
  out_hold_a: assert property (!out_valid_out |->
    $stable(out_norm_out) && $stable(out_byte_out))
    else $error("output moved without strobe");
  ready_a: assert property (pready_out)
    else $error("ready low");
  err_cause_a: assert property (pslverr_out |-> acc_ph && !mapped)
    else $error("error without cause");
  err_need_a: assert property (acc_ph && !mapped |-> pslverr_out)
    else $error("unmapped access not refused");
  zero_byte_a: assert property (out_valid_out && !acc_r &&
    !$past(acc_r) && !$past(acc_r, 2) |-> out_byte_out == 8'h00)
    else $error("table byte not zero");
  peak_sext_a: assert property (acc_ph && !pwrite_in &&
    paddr_in == 8'h04 |-> prdata_out[31:22] == {10{prdata_out[21]}})
    else $error("peak read not sign extended");
endmodule
bind mbpp_top mbpp_top_asserts u_mbpp_top_asserts (.*);
`default_nettype wire

// >>> mbpp_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbpp_mac_model (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [21:0] val_in,
  output logic             res_valid_out,
  output logic      [21:0] res_data_out
);
  // ========
  // Idle bus
  // A changing pattern between results, so sampling without strobe shows
  logic [21:0] idle_r = 22'h155555;
  always @(posedge clk_in) idle_r <= ~idle_r;
  assign res_valid_out = go_in;
  assign res_data_out  = go_in ? val_in : idle_r;
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbpp_regs.svh"
module tb_top;
  import mbpp_pkg::*;
  logic        clk_in = 1'h0, srst_in = 1'h1, psel_in = 1'h0, go = 1'h0;
  logic        penable_in = 1'h0, pwrite_in = 1'h0, pready_out, pslverr_out;
  logic        res_valid_in, out_valid_out, erv;
  logic [7:0]  paddr_in = 8'h00, out_byte_out, t;
  logic [21:0] res_data_in, out_norm_out, gov = 22'h0, x, e, th;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdv, seed = 32'h7ad5;
  logic [15:0] c;
  int          error_cnt = 0, n_tests = 0;
  mbpp_top u_mbpp_top (.*);
  mbpp_mac_model u_mbpp_mac_model (
    .clk_in       (clk_in),
    .go_in        (go),
    .val_in       (gov),
    .res_valid_out(res_valid_in),
    .res_data_out (res_data_in)
  );
  always #5 clk_in = ~clk_in;
  // ========
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [21:0] rect(input logic [21:0] v, input int m);
    if (!v[21]) return v;
    if (m == 2) return 22'h0;
    if (v == 22'h200000) return 22'h1fffff;
    return 22'h0 - v;
  endfunction
  function automatic logic [31:0] tw(input int w, input logic [7:0] l);
    for (int b = 0; b < 4; b++) tw[8*b +: 8] = (4*w + b > l) ? 8'h1 : 8'h0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_tests++;
    if (g !== ex) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, ex, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in   <= 1'h1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'h1;
    do @(posedge clk_in); while (pready_out !== 1'h1);
    rdv = prdata_out;
    erv = pslverr_out;
    psel_in    <= 1'h0;
    penable_in <= 1'h0;
  endtask
  // Output lands two edges after the result is taken
  task automatic send(input logic [21:0] v);
    @(posedge clk_in);
    go  <= 1'h1;
    gov <= v;
    @(posedge clk_in);
    go <= 1'h0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    final_report();
  end
  // ========
  // Scenarios
  initial begin
    repeat (2) @(posedge clk_in);
    srst_in <= 1'h0;
    apb(1'h0, `MBPP_OFS_PEAK, 32'h0);
    chk("peak reset", 32'hffe00000, rdv);
    chk("mapped err", 32'h0, 32'(erv));
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, 32'(erv));
    for (int m = 1; m < 3; m++) begin
      // Dynamic bit set with access 0: the static shift must still rule
      apb(1'h1, `MBPP_OFS_CTRL, 32'(m << 1) | 32'h20 | 32'(m << 6));
      for (int i = 0; i < 12; i++) begin
        x = (i == 0) ? 22'h200000 : 22'(rnd());
        send(x);
        e = rect(x, m) >> m;
        chk("norm", 32'(e), 32'(out_norm_out));
        chk("byte", 32'h0, 32'(out_byte_out));
      end
    end
    for (int k = 1; k < 5; k++) begin
      e = (k == 2) ? 22'h1fffff : 22'h200000;
      th = (k == 4) ? 22'h0 : 22'(rnd());
      c = (k == 4) ? 16'hfffa : 16'h0;
      apb(1'h1, `MBPP_OFS_PEAK, 32'(e));
      apb(1'h1, `MBPP_OFS_THRESH, 32'(th));
      apb(1'h1, `MBPP_OFS_EXCEED, 32'(c));
      apb(1'h1, `MBPP_OFS_CTRL, 32'((k > 2 ? 3 : k) << 3));
      for (int i = 0; i < 30; i++) begin
        x = 22'(rnd());
        @(posedge clk_in);
        go  <= 1'h1;
        gov <= x;
        if (k == 1 && $signed(x) > $signed(e)) e = x;
        if (k == 2 && $signed(x) < $signed(e)) e = x;
        if (k > 2 && $signed(x) > $signed(th) && c != 16'hffff) c++;
      end
      @(posedge clk_in);
      go <= 1'h0;
      apb(1'h0, k > 2 ? `MBPP_OFS_EXCEED : `MBPP_OFS_PEAK, 32'h0);
      if (k < 3) chk("peak", {{10{e[21]}}, e}, rdv);
      else chk("exceed", 32'(c), rdv);
    end
    t = 8'(rnd());
    apb(1'h1, `MBPP_OFS_CTRL, 32'h2);
    for (int w = 0; w < 64; w++) begin
      apb(1'h1, `MBPP_OFS_LUTADR, 32'(w));
      apb(1'h1, `MBPP_OFS_LUTDAT, tw(w, t));
    end
    apb(1'h1, `MBPP_OFS_LUTADR, 32'h21);
    apb(1'h0, `MBPP_OFS_LUTDAT, 32'h0);
    chk("table word", tw(33, t), rdv);
    apb(1'h1, `MBPP_OFS_CTRL, 32'h3);
    apb(1'h0, `MBPP_OFS_LUTDAT, 32'h0);
    chk("table locked", 32'h0, rdv);
    for (int i = 0; i < 24; i++) begin
      x = 22'(rnd() & 32'h1ff) - 22'h100;
      send(x);
      chk("thr norm", 32'(rect(x, 1)), 32'(out_norm_out));
      e = rect(x, 1);
      e = (e > 22'hff) ? 22'hff : e;
      chk("thr byte", 32'(e > 22'(t)), 32'(out_byte_out));
    end
    final_report();
  end
endmodule
`default_nettype wire
